//--- logic/pmx_pkg.sv
// Constants for the port pin function select block
`default_nettype none
package pmx_pkg;
  // ************************************************************
  // Register word indices (byte address is index times four)
  // ************************************************************
  localparam logic [2:0] IDX_PA_CTL = 3'h0;
  localparam logic [2:0] IDX_PD_CTL1 = 3'h1;
  localparam logic [2:0] IDX_PD_CTL2 = 3'h2;
  localparam logic [2:0] IDX_GP_OUT = 3'h3;
  localparam logic [2:0] IDX_GP_DIR = 3'h4;
  localparam logic [2:0] IDX_GP_IN = 3'h5;
  // ************************************************************
  // Writable bit masks and reset values
  // ************************************************************
  localparam logic [15:0] MASK_PA_CTL = 16'h0773;
  localparam logic [15:0] MASK_PD_CTL1 = 16'h0003;
  localparam logic [15:0] MASK_PD_CTL2 = 16'h3333;
  localparam logic [15:0] MASK_GP = 16'h00ff;
  localparam logic [15:0] RST_CTL = 16'h0000;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LSB_A26 = 8;
  localparam int LSB_A25 = 4;
  localparam int LSB_A24 = 0;
  localparam int LSB_D8 = 0;
  localparam int LSB_D7 = 12;
  localparam int LSB_D6 = 8;
  localparam int LSB_D5 = 4;
  localparam int LSB_D4 = 0;
  // ************************************************************
  // Pad indices and function codes
  // ************************************************************
  localparam int NPIN = 8;
  localparam int PIN_A26 = 0;
  localparam int PIN_A25 = 1;
  localparam int PIN_A24 = 2;
  localparam int PIN_D8 = 3;
  localparam int PIN_D7 = 4;
  typedef logic [2:0] pmx_code_t;
  localparam pmx_code_t FN_PORT = 3'h0;
  localparam pmx_code_t FN_ALT1 = 3'h1;
  localparam pmx_code_t FN_ALT2 = 3'h2;
  localparam pmx_code_t FN_ALT3 = 3'h3;
endpackage
`default_nettype wire

//--- logic/pmx_wb_slave.sv
// Classic Wishbone slave front end for the pin select registers
`default_nettype none
module pmx_wb_slave (
  input wire logic clk_i,               // Peripheral clock
  input wire logic rst_i,               // Synchronous reset
  input wire logic cyc_i,               // Bus cycle
  input wire logic stb_i,               // Strobe
  input wire logic we_i,                // Write enable
  input wire logic [15:0] rd_data_i,    // Selected register value
  output logic ack_o,                   // Acknowledge
  output logic [31:0] dat_o,            // Read data
  output logic wr_o                     // Write commit pulse
);
  // ************************************************************
  // Handshake
  // ************************************************************
  // Ack one cycle after request, dropped in the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  // Read data captured as ack rises, upper half reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack_o & ~we_i) begin
      dat_o <= {16'h0000, rd_data_i};
    end
  end

  // Write lands on the edge where the master sees ack
  assign wr_o = cyc_i & stb_i & we_i & ack_o;
endmodule
`default_nettype wire

//--- logic/pmx_pad_cell.sv
// One pad: picks port or one of three alternate drivers
`default_nettype none
module pmx_pad_cell (
  input wire logic clk_i,                 // Peripheral clock
  input wire logic rst_i,                 // Synchronous reset
  input wire pmx_pkg::pmx_code_t code_i,  // Function code
  input wire logic gp_out_i,              // Port output value
  input wire logic gp_dir_i,              // Port direction, 1 drives
  input wire logic [3:1] alt_out_i,       // Alternate output values
  input wire logic [3:1] alt_oe_i,        // Alternate drive enables
  output logic pad_out_o,                 // Pad output value
  output logic pad_oe_o                   // Pad drive enable
);
  import pmx_pkg::*;

  // ************************************************************
  // Driver select
  // ************************************************************
  // Code 0 gives the port, 1 to 3 an alternate, others release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o <= 1'b0;
      pad_oe_o <= 1'b0;
    end else begin
      case (code_i)
        FN_PORT: begin
          pad_out_o <= gp_out_i;
          pad_oe_o <= gp_dir_i;
        end
        FN_ALT1, FN_ALT2, FN_ALT3: begin
          pad_out_o <= alt_out_i[code_i[1:0]];
          pad_oe_o <= alt_oe_i[code_i[1:0]];
        end
        default: begin
          pad_out_o <= 1'b0;
          pad_oe_o <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- logic/pmx_pin_select.sv
// Pin function select for port A and port D pads with registers
`default_nettype none
module pmx_pin_select (
  input wire logic clk_i,                  // Peripheral clock
  input wire logic rst_i,                  // Synchronous reset
  input wire logic wb_cyc_i,               // Wishbone cycle
  input wire logic wb_stb_i,               // Wishbone strobe
  input wire logic wb_we_i,                // Wishbone write
  input wire logic [4:2] wb_adr_i,         // Word address
  input wire logic [3:0] wb_sel_i,         // Byte selects
  input wire logic [31:0] wb_dat_i,        // Write data
  output logic [31:0] wb_dat_o,            // Read data
  output logic wb_ack_o,                   // Acknowledge
  input wire logic [7:0] pad_in_i,         // Pad levels
  output logic [7:0] pad_out_o,            // Pad output values
  output logic [7:0] pad_oe_o,             // Pad drive enables
  input wire logic bus_addr_bit_26_i,      // Bus address bit 26
  input wire logic bus_addr_bit_25_i,      // Bus address bit 25
  input wire logic bus_addr_bit_24_i,      // Bus address bit 24
  input wire logic dma_ch3_active_out_i,   // DMA3 transfer active
  input wire logic dma_ch3_ack_out_i,      // DMA3 acknowledge
  output logic dma_ch3_request_in_o,       // DMA3 request from pad
  output logic pin_irq_alt_two_o,          // Pin irq from A26
  output logic pin_irq_alt_zero_o,         // Pin irq from A24
  output logic serial0_receive_line_o,     // Serial 0 receive
  input wire logic serial0_transmit_line_i,// Serial 0 transmit
  input wire logic dma_ch1_end_out_i,      // DMA1 transfer end
  input wire logic dma_ch1_active_out_i,   // DMA1 transfer active
  input wire logic timer0_compare_line_a_i,  // Timer A out value
  input wire logic timer0_compare_a_oe_i,    // Timer A drive
  output logic timer0_compare_line_a_o,      // Timer A pad level
  input wire logic timer0_compare_line_b_i,  // Timer B out value
  input wire logic timer0_compare_b_oe_i,    // Timer B drive
  output logic timer0_compare_line_b_o       // Timer B pad level
);
  import pmx_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [15:0] pa_ctl;
  logic [15:0] pd_ctl1;
  logic [15:0] port_d_pin_select_two;
  logic [15:0] gp_out;
  logic [15:0] gp_dir;
  logic [7:0] pad_meta;
  logic [7:0] pad_sync;
  logic [15:0] rd_data;
  logic wr;
  pmx_code_t pin_code [NPIN];
  logic [3:1] alt_out [NPIN];
  logic [3:1] alt_oe [NPIN];
  pmx_code_t pin_a26_function_field;
  pmx_code_t pin_a25_function_field;
  logic [1:0] pin_a24_function_field;
  logic [1:0] pin_d8_function_field;
  logic [1:0] pin_d7_function_field;
  logic [1:0] pin_d6_function_field;
  logic [1:0] pin_d5_function_field;
  logic [1:0] pin_d4_function_field;

  // Byte-lane merge of write data, clipped to writable bits
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel,
    input logic [15:0] mask
  );
    logic [15:0] m;
    m = old_v;
    if (sel[0]) m[7:0] = new_v[7:0];
    if (sel[1]) m[15:8] = new_v[15:8];
    return m & mask;
  endfunction

  // ************************************************************
  // Bus slave
  // ************************************************************
  pmx_wb_slave u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .we_i(wb_we_i),
    .rd_data_i(rd_data),
    .ack_o(wb_ack_o),
    .dat_o(wb_dat_o),
    .wr_o(wr)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_ctl <= RST_CTL;
      pd_ctl1 <= RST_CTL;
      gp_out <= RST_CTL;
      gp_dir <= RST_CTL;
    end else if (wr) begin
      case (wb_adr_i)
        IDX_PA_CTL: pa_ctl <= lane_merge(pa_ctl, wb_dat_i,
                                         wb_sel_i, MASK_PA_CTL);
        IDX_PD_CTL1: pd_ctl1 <= lane_merge(pd_ctl1, wb_dat_i,
                                           wb_sel_i, MASK_PD_CTL1);
        IDX_GP_OUT: gp_out <= lane_merge(gp_out, wb_dat_i,
                                         wb_sel_i, MASK_GP);
        IDX_GP_DIR: gp_dir <= lane_merge(gp_dir, wb_dat_i,
                                         wb_sel_i, MASK_GP);
        default: begin
        end
      endcase
    end
  end

  // port D register two, zero at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_d_pin_select_two <= RST_CTL;
    end else if (wr && wb_adr_i == IDX_PD_CTL2) begin
      port_d_pin_select_two <= lane_merge(port_d_pin_select_two,
                                          wb_dat_i, wb_sel_i,
                                          MASK_PD_CTL2);
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    case (wb_adr_i)
      IDX_PA_CTL: rd_data = pa_ctl;
      IDX_PD_CTL1: rd_data = pd_ctl1;
      IDX_PD_CTL2: rd_data = port_d_pin_select_two;
      IDX_GP_OUT: rd_data = gp_out;
      IDX_GP_DIR: rd_data = gp_dir;
      IDX_GP_IN: rd_data = {8'h00, pad_sync};
      default: rd_data = 16'h0000;
    endcase
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  // Mode fields pulled out of the control words
  assign pin_a26_function_field = pa_ctl[LSB_A26 +: 3];
  assign pin_a25_function_field = pa_ctl[LSB_A25 +: 3];
  assign pin_a24_function_field = pa_ctl[LSB_A24 +: 2];
  assign pin_d8_function_field = pd_ctl1[LSB_D8 +: 2];
  assign pin_d7_function_field = port_d_pin_select_two[LSB_D7 +: 2];
  assign pin_d6_function_field = port_d_pin_select_two[LSB_D6 +: 2];
  assign pin_d5_function_field = port_d_pin_select_two[LSB_D5 +: 2];
  assign pin_d4_function_field = port_d_pin_select_two[LSB_D4 +: 2];

  assign pin_code[0] = pin_a26_function_field;
  assign pin_code[1] = pin_a25_function_field;
  assign pin_code[2] = {1'b0, pin_a24_function_field};
  assign pin_code[3] = {1'b0, pin_d8_function_field};
  assign pin_code[4] = {1'b0, pin_d7_function_field};
  assign pin_code[5] = {1'b0, pin_d6_function_field};
  assign pin_code[6] = {1'b0, pin_d5_function_field};
  assign pin_code[7] = {1'b0, pin_d4_function_field};

  // ************************************************************
  // Alternate drivers per pad (input functions leave pad free)
  // ************************************************************
  // A26: address, DMA3 active, irq input
  assign alt_out[PIN_A26] = {1'b0, dma_ch3_active_out_i,
                             bus_addr_bit_26_i};
  assign alt_oe[PIN_A26] = 3'b011;
  assign alt_out[PIN_A25] = {dma_ch3_ack_out_i, 1'b0,
                             bus_addr_bit_25_i};
  assign alt_oe[PIN_A25] = 3'b101;
  assign alt_out[PIN_A24] = {2'b00, bus_addr_bit_24_i};
  assign alt_oe[PIN_A24] = 3'b001;
  // D8: receive input, DMA1 end, timer B two-way
  assign alt_out[PIN_D8] = {timer0_compare_line_b_i,
                            dma_ch1_end_out_i, 1'b0};
  assign alt_oe[PIN_D8] = {timer0_compare_b_oe_i, 2'b10};
  // D7: transmit, DMA1 active, timer A two-way
  assign alt_out[PIN_D7] = {timer0_compare_line_a_i,
                            dma_ch1_active_out_i,
                            serial0_transmit_line_i};
  assign alt_oe[PIN_D7] = {timer0_compare_a_oe_i, 2'b11};

  // pad cells pick port or alternate driver
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_pad
      if (i > PIN_D7) begin : g_free
        // Alternates of D6 to D4 live outside; pads released
        assign alt_out[i] = 3'b000;
        assign alt_oe[i] = 3'b000;
      end
      pmx_pad_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .code_i(pin_code[i]),
        .gp_out_i(gp_out[i]),
        .gp_dir_i(gp_dir[i]),
        .alt_out_i(alt_out[i]),
        .alt_oe_i(alt_oe[i]),
        .pad_out_o(pad_out_o[i]),
        .pad_oe_o(pad_oe_o[i])
      );
    end
  endgenerate

  // ************************************************************
  // Pad inputs to peripherals
  // ************************************************************
  // Two-stage synchroniser on pad levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_meta <= 8'h00;
      pad_sync <= 8'h00;
    end else begin
      pad_meta <= pad_in_i;
      pad_sync <= pad_meta;
    end
  end

  // route pad level only to the selected input function
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_irq_alt_two_o <= 1'b0;
      dma_ch3_request_in_o <= 1'b0;
      pin_irq_alt_zero_o <= 1'b0;
      serial0_receive_line_o <= 1'b1;
      timer0_compare_line_b_o <= 1'b0;
      timer0_compare_line_a_o <= 1'b0;
    end else begin
      pin_irq_alt_two_o <= (pin_a26_function_field == FN_ALT3)
                           & pad_sync[PIN_A26];
      dma_ch3_request_in_o <= (pin_code[PIN_A24] == FN_ALT2)
                              & pad_sync[PIN_A24];
      pin_irq_alt_zero_o <= (pin_code[PIN_A24] == FN_ALT3)
                            & pad_sync[PIN_A24];
      // Receive idles high when not routed
      serial0_receive_line_o <= (pin_code[PIN_D8] == FN_ALT1)
                                ? pad_sync[PIN_D8] : 1'b1;
      timer0_compare_line_b_o <= (pin_code[PIN_D8] == FN_ALT3)
                                 & pad_sync[PIN_D8];
      timer0_compare_line_a_o <= (pin_code[PIN_D7] == FN_ALT3)
                                 & pad_sync[PIN_D7];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_a26_addr;
    pin_a26_function_field == FN_ALT1 |=>
      pad_oe_o[0] && pad_out_o[0] == $past(bus_addr_bit_26_i);
  endproperty
  a_a26_addr: assert property (p_a26_addr)
    else $error("A26 address not on pad");

  property p_a26_bad;
    pin_a26_function_field[2] |=> !pad_oe_o[0];
  endproperty
  a_a26_bad: assert property (p_a26_bad)
    else $error("A26 driven with prohibited code");

  property p_a25_ack;
    pin_a25_function_field == FN_ALT3 |=>
      pad_oe_o[1] && pad_out_o[1] == $past(dma_ch3_ack_out_i);
  endproperty
  a_a25_ack: assert property (p_a25_ack)
    else $error("A25 ack not on pad");

  property p_a24_req;
    pin_a24_function_field == 2'h2 ##1 pin_a24_function_field == 2'h2
      |-> dma_ch3_request_in_o == $past(pad_sync[2]);
  endproperty
  a_a24_req: assert property (p_a24_req)
    else $error("A24 request not routed");

  property p_d8_rx;
    pin_d8_function_field == 2'h1 |=>
      !pad_oe_o[3] && serial0_receive_line_o == $past(pad_sync[3]);
  endproperty
  a_d8_rx: assert property (p_d8_rx)
    else $error("D8 receive not routed");

  property p_d7_dact;
    pin_d7_function_field == 2'h2 |=>
      pad_oe_o[4] && pad_out_o[4] == $past(dma_ch1_active_out_i);
  endproperty
  a_d7_dact: assert property (p_d7_dact)
    else $error("D7 DMA1 active not on pad");

  property p_resv_zero;
    wb_ack_o && !wb_we_i |-> (wb_dat_o[31:16] == 16'h0000) &&
      (wb_adr_i != IDX_PA_CTL || (wb_dat_o[15:0] & ~MASK_PA_CTL) == 0);
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("Reserved bits read nonzero");

  // Reset is the trigger here, so the default disable must not apply
  property p_pd2_reset;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> port_d_pin_select_two == 16'h0000;
  endproperty
  a_pd2_reset: assert property (p_pd2_reset)
    else $error("Port D register two not cleared");

  property p_port_mode;
    pin_code[5] == FN_PORT |=>
      pad_oe_o[5] == $past(gp_dir[5]) && pad_out_o[5] == $past(gp_out[5]);
  endproperty
  a_port_mode: assert property (p_port_mode)
    else $error("Port mode does not follow GPIO");
endmodule
`default_nettype wire

//--- verification/pmx_far_model.sv
// Peripheral and board model on the far side of the pads
`default_nettype none
module pmx_far_model (
  input wire logic clk_i,           // Bench clock
  input wire logic shuffle_i,       // Take new levels
  input wire logic [31:0] rnd_i,    // Random word
  input wire logic [7:0] pad_out_i, // Chip pad values
  input wire logic [7:0] pad_oe_i,  // Chip drive enables
  output logic [7:0] pad_in_o,      // Levels on the pads
  output logic [11:0] src_o         // Peripheral levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // Start quiet so no board or peripheral level is unknown at time zero
  logic [7:0] board = 8'h00;
  logic [11:0] src = 12'h000;
  // ************
  // Levels
  // ************
  // New levels just after an edge, held until the next request
  always @(posedge clk_i) begin
    if (shuffle_i) begin
      src <= rnd_i[11:0];
      board <= rnd_i[19:12];
    end
  end
  // Peripheral levels come from one process only
  assign src_o = src;
  // A driven pad shows the chip value, a released one the board
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board);
endmodule
`default_nettype wire

//--- verification/port_pin_function_select_tb.sv
// Self-checking bench for the port pin function select block
`default_nettype none
module port_pin_function_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmx_pkg::*;
  typedef struct {string name; logic [31:0] val;} pmx_note_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic shuf = 1'b0;
  logic probe = 1'b0;
  logic [2:0] adr = 3'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rnd = 32'h0;
  logic [31:0] v;
  logic [31:0] got;
  logic [2:0] k;
  logic [15:0] sh [8];
  wire logic [31:0] dat_o;
  wire logic ack;
  wire logic [7:0] pin, pout, poe;
  wire logic [11:0] src;
  wire logic [5:0] rt;
  integer seed = 75;
  int n_errors = 0;
  int n_tests = 0;
  pmx_note_s q [$];
  pmx_note_s nt;
  // ************
  // Structure
  // ************
  // Block under test
  pmx_pin_select uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pad_in_i(pin),
    .pad_out_o(pout), .pad_oe_o(poe),
    .bus_addr_bit_26_i(src[0]), .bus_addr_bit_25_i(src[1]),
    .bus_addr_bit_24_i(src[2]), .dma_ch3_active_out_i(src[3]),
    .dma_ch3_ack_out_i(src[4]), .dma_ch3_request_in_o(rt[5]),
    .pin_irq_alt_two_o(rt[4]), .pin_irq_alt_zero_o(rt[3]),
    .serial0_receive_line_o(rt[2]), .serial0_transmit_line_i(src[5]),
    .dma_ch1_end_out_i(src[6]), .dma_ch1_active_out_i(src[7]),
    .timer0_compare_line_a_i(src[8]), .timer0_compare_a_oe_i(src[9]),
    .timer0_compare_line_a_o(rt[1]), .timer0_compare_line_b_i(src[10]),
    .timer0_compare_b_oe_i(src[11]), .timer0_compare_line_b_o(rt[0])
  );
  // Peripherals and board
  pmx_far_model far (
    .clk_i(clk_i), .shuffle_i(shuf), .rnd_i(rnd), .pad_out_i(pout),
    .pad_oe_i(poe), .pad_in_o(pin), .src_o(src)
  );
  // Free-running 100 ns clock
  always #50 clk_i = ~clk_i;
  // ************
  // Checking
  // ************
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Each read answer or pad snapshot meets the oldest note
  always @(posedge clk_i) begin
    if ((ack === 1'b1 && cyc === 1'b1 && we === 1'b0) || probe) begin
      if (q.size() == 0) begin
        check("note queue", 32'h1, 32'h0);
      end else begin
        nt = q.pop_front();
        got = probe ? {10'h0, rt, poe, pout & poe} : dat_o;
        check(nt.name, got, nt.val);
      end
    end
  end
  // Writable bits of each word
  function automatic logic [15:0] msk(input logic [2:0] a);
    case (a)
      IDX_PA_CTL: return MASK_PA_CTL;
      IDX_PD_CTL1: return MASK_PD_CTL1;
      IDX_PD_CTL2: return MASK_PD_CTL2;
      IDX_GP_OUT, IDX_GP_DIR: return MASK_GP;
      default: return 16'h0000;
    endcase
  endfunction
  // Expected routed inputs, drive enables and driven values
  function automatic logic [21:0] exp_pads();
    logic [1:0] p [8];
    logic [5:0] r;
    logic [7:0] e;
    logic [7:0] o;
    logic [15:0] pa;
    logic [15:0] pd;
    pa = sh[IDX_PA_CTL];
    pd = sh[IDX_PD_CTL2];
    r = 6'h04;
    for (int i = 0; i < 8; i++) begin
      p[i] = {sh[IDX_GP_DIR][i], sh[IDX_GP_OUT][i]};
    end
    case (pa[10:8])
      3'h0: ;
      3'h1: p[0] = {1'b1, src[0]};
      3'h2: p[0] = {1'b1, src[3]};
      default: p[0] = 2'b00;
    endcase
    if (pa[10:8] == 3'h3) r[4] = pin[0];
    case (pa[6:4])
      3'h0: ;
      3'h1: p[1] = {1'b1, src[1]};
      3'h3: p[1] = {1'b1, src[4]};
      default: p[1] = 2'b00;
    endcase
    if (pa[1:0] == 2'h1) p[2] = {1'b1, src[2]};
    if (pa[1]) p[2] = 2'b00;
    if (pa[1:0] == 2'h2) r[5] = pin[2];
    if (pa[1:0] == 2'h3) r[3] = pin[2];
    case (sh[IDX_PD_CTL1][1:0])
      2'h1: {p[3], r[2]} = {2'b00, pin[3]};
      2'h2: p[3] = {1'b1, src[6]};
      2'h3: {p[3], r[0]} = {src[11], src[10], pin[3]};
      default: ;
    endcase
    case (pd[13:12])
      2'h1: p[4] = {1'b1, src[5]};
      2'h2: p[4] = {1'b1, src[7]};
      2'h3: {p[4], r[1]} = {src[9], src[8], pin[4]};
      default: ;
    endcase
    for (int j = 5; j < 8; j++) begin
      if (pd[13-4*(j-4) -: 2] != 2'h0) p[j] = 2'b00;
    end
    for (int i = 0; i < 8; i++) {e[i], o[i]} = {p[i][1], &p[i]};
    return {r, e, o};
  endfunction
  // ************
  // Driving
  // ************
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [2:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      check("ack wait", 32'h0, 32'h1);
      give_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Write and keep the shadow copy
  task automatic wr(input logic [2:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & msk(a);
    sh[a] = (sh[a] & ~m) | (d[15:0] & m);
    wb(1'b1, a, d, s);
  endtask
  // Read with its expected value noted first
  task automatic rd(input logic [2:0] a);
    v = {16'h0, a == IDX_GP_IN ? {8'h00, pin} : sh[a]};
    q.push_back('{$sformatf("reg %0d", a), v});
    wb(1'b0, a, 32'h0, 4'h3);
  endtask
  // New random levels on peripherals and board
  task automatic shake();
    @(posedge clk_i);
    rnd <= $random(seed);
    shuf <= 1'b1;
    @(posedge clk_i);
    shuf <= 1'b0;
  endtask
  // Let pads and synchronisers settle, then snapshot them
  task automatic snap(input string nm);
    repeat (5) @(posedge clk_i);
    q.push_back('{nm, {10'h0, exp_pads()}});
    probe <= 1'b1;
    @(posedge clk_i);
    probe <= 1'b0;
  endtask
  // Main sequence
  initial begin
    for (int a = 0; a < 8; a++) sh[a] = 16'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    snap("reset pads");
    // Reserved and unmapped bits written as ones on purpose
    for (int a = 0; a < 8; a++) wr(a[2:0], 32'hffffffff, 4'hf);
    wr(IDX_PD_CTL2, 32'h0, 4'h1);
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    // Every mode code of pins A26 to D7, random codes on D6 to D4, with random levels around
    for (int n = 0; n < 24; n++) begin
      k = n[2:0];
      shake();
      v = $random(seed);
      wr(IDX_PA_CTL, {k, 1'b0, k, 2'b00, k[1:0]}, 4'h3);
      wr(IDX_PD_CTL1, {30'h0, k[1:0]}, 4'h3);
      wr(IDX_PD_CTL2, {k[1:0], 12'h0} | (v[15:0] & 16'h0333), 4'h3);
      wr(IDX_GP_OUT, v[31:24], 4'h3);
      wr(IDX_GP_DIR, v[23:16], 4'h3);
      rd(IDX_PA_CTL);
      snap("pads");
      rd(IDX_GP_IN);
    end
    // A second reset in mid-run clears every field
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) sh[a] = 16'h0;
    for (int a = 0; a < 8; a++) rd(a[2:0]);
    snap("pads after reset");
    // Let the checker take the last snapshot before closing
    repeat (2) @(posedge clk_i);
    check("notes left", q.size(), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
